// file: dv/ifr_bus_node.sv
// Model of another node sharing the link with the responder
`timescale 1ns/1ps
module ifr_bus_node (
    // Responder drive
    input  wire logic txBit,
    input  wire logic txEn,
    // Competing node sends the opposite bit
    input  wire logic jam,
    // Bus level seen by all nodes
    output logic      busLevel
);
    // Passive bus rests low
    assign busLevel = txEn ? (txBit ^ jam) : 1'b0;
endmodule

// file: dv/ifr_tx_ctrl_checker.sv
// Port-level assertions of the in-frame response transmit control
`timescale 1ns/1ps
module ifr_tx_ctrl_checker (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          reset,
    // Register port and symbol events
    input  ifr_pkg::ifrRegReq_s regReq,
    input  wire logic [7:0]    rdData,
    input  ifr_pkg::ifrRxEvt_s  rxEvt,
    // Link and status
    input  wire logic          busRxPin,
    input  wire logic          txBit,
    input  wire logic          txEn,
    input  wire logic          txEmpty,
    input  wire logic          lostArb
);
    import ifr_pkg::*;
    logic blk_ff;
    // Window from end of data to end of frame
    always_ff @(posedge clock) begin
        blk_ff <= !reset && (rxEvt.eodRx || (blk_ff && !rxEvt.eofRx));
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_ctrlWr;
        regReq.wr && regReq.addr == ADDR_CTRL && !regReq.wdata[CTL_EOD]
            && !blk_ff && !rxEvt.eodRx && !rxEvt.busError;
    endsequence
    sequence s_ctrlRd;
        regReq.rd && regReq.addr == ADDR_CTRL && !rxEvt.busError;
    endsequence
    property p_readBack;
        s_ctrlWr ##1 !regReq.wr && !rxEvt.busError ##1 s_ctrlRd
            |=> rdData[2:0] == $past(regReq.wdata[2:0], 3);
    endproperty
    a_readBack: assert property (p_readBack)
        else $error("read back differs");
    property p_rdIdle;
        !regReq.rd |=> rdData == 8'h00;
    endproperty
    a_rdIdle: assert property (p_rdIdle)
        else $error("read data not zero");
    property p_resetQuiet;
        $fell(reset) |-> !txEn && !txEmpty && !lostArb && rdData == 8'h00;
    endproperty
    a_resetQuiet: assert property (p_resetQuiet)
        else $error("not quiet after reset");
    property p_holdBit;
        $rose(txEn) |=> (txEn && $stable(txBit))[*8];
    endproperty
    a_holdBit: assert property (p_holdBit)
        else $error("driven bit not held");
    property p_txInFrame;
        $rose(txEn) |-> blk_ff;
    endproperty
    a_txInFrame: assert property (p_txInFrame)
        else $error("drive outside window");
    property p_lostCause;
        $rose(lostArb) |-> $past(txEn) || $past(txEn, 2);
    endproperty
    a_lostCause: assert property (p_lostCause)
        else $error("lost flag without driving");
    property p_lostClear;
        regReq.rd && regReq.addr == ADDR_STAT && !txEn && !$past(txEn)
            |=> !lostArb;
    endproperty
    a_lostClear: assert property (p_lostClear)
        else $error("lost flag not cleared");
    property p_eodClears;
        regReq.wr && regReq.addr == ADDR_CTRL && regReq.wdata[CTL_EOD]
            |=> !txEmpty;
    endproperty
    a_eodClears: assert property (p_eodClears)
        else $error("empty kept after end request");
endmodule
bind ifr_tx_ctrl ifr_tx_ctrl_checker u_chk (.clock(clock), .reset(reset),
    .regReq(regReq), .rdData(rdData), .rxEvt(rxEvt), .busRxPin(busRxPin),
    .txBit(txBit), .txEn(txEn), .txEmpty(txEmpty), .lostArb(lostArb));

// file: dv/tb_top.sv
// Self-checking bench of the in-frame response transmit control
`timescale 1ns/1ps
module tb_top;
    import ifr_pkg::*;
    logic        clock;
    logic        reset;
    ifrRegReq_s  regReq;
    ifrRxEvt_s   rxEvt;
    logic [7:0]  rdData;
    logic        txBit;
    logic        txEn;
    logic        txEmpty;
    logic        lostArb;
    logic        jam;
    logic        busLevel;
    int          failCount;
    int          samplesChecked;
    logic [7:0]  rv;
    logic [7:0]  crc;
    logic [16:0] bits;
    // Clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    ifr_tx_ctrl u_dut (.clock(clock), .reset(reset), .regReq(regReq),
        .rdData(rdData), .rxEvt(rxEvt), .busRxPin(busLevel), .txBit(txBit),
        .txEn(txEn), .txEmpty(txEmpty), .lostArb(lostArb));
    ifr_bus_node u_node (.txBit(txBit), .txEn(txEn), .jam(jam),
        .busLevel(busLevel));
    task automatic completeRun();
        $display("checks %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [16:0] got, input logic [16:0] exp,
                         input string what);
        samplesChecked++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED %0t %s got %h", $time, what, got);
        end
    endtask
    task automatic wrReg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        regReq.addr  <= a;
        regReq.wdata <= d;
        regReq.wr    <= 1'b1;
        @(posedge clock);
        regReq.wr <= 1'b0;
    endtask
    task automatic rdReg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock);
        regReq.addr <= a;
        regReq.rd   <= 1'b1;
        @(posedge clock);
        regReq.rd <= 1'b0;
        #1;
        d = rdData;
    endtask
    // Symbol event pulse: 0 end of data, 1 end of frame, 2 bus error
    task automatic pulse(input int which);
        @(posedge clock);
        rxEvt <= ifrRxEvt_s'(3'b100 >> which);
        @(posedge clock);
        rxEvt <= '0;
    endtask
    // Bounded wait: 0 driving, 1 transmit empty, 2 released
    task automatic waitFor(input int sel);
        int n;
        n = 0;
        while (!(sel == 0 ? txEn === 1'b1 : sel == 1 ? txEmpty === 1'b1
                 : txEn === 1'b0) && n < 20000) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 20000) begin
            failCount++;
            $display("CHECK FAILED %0t wait %0d ran out", $time, sel);
            completeRun();
        end
    endtask
    // Sample n bits mid period, first bit most significant
    task automatic getBits(input int n, output logic [16:0] b);
        b = '0;
        waitFor(0);
        repeat (800) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            #1;
            b = {b[15:0], txBit};
            repeat (1600) @(posedge clock);
        end
    endtask
    initial begin
        #4000000;
        failCount++;
        $display("CHECK FAILED %0t run too long", $time);
        completeRun();
    end
    initial begin
        reset = 1'b1;
        regReq = '0;
        rxEvt = '0;
        jam = 1'b0;
        failCount = 0;
        samplesChecked = 0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        rdReg(ADDR_CTRL, rv);
        check(17'(rv), 17'(CTRL_RST), "ctrl reset");
        wrReg(2'h3, 8'hff);
        rdReg(2'h3, rv);
        check(17'(rv), 17'h0, "unmapped");
        // Patterns 3 to 7, all conflicting except 4, read back as written
        for (int p = 3; p < 8; p++) begin
            wrReg(ADDR_CTRL, 8'(p));
            rdReg(ADDR_CTRL, rv);
            check(17'(rv), 17'(p), "pattern");
        end
        wrReg(ADDR_CTRL, 8'h00);
        $display("test readback done");
        // Single byte response, format select 1
        wrReg(ADDR_DATA, 8'ha5);
        wrReg(ADDR_CTRL, 8'h14);
        pulse(0);
        getBits(9, bits);
        check(bits, 17'h1a5, "single frame");
        waitFor(2);
        rdReg(ADDR_CTRL, rv);
        check(17'(rv), 17'h10, "single clear");
        pulse(1);
        $display("test single done");
        // Both multi requests: check mode wins
        crc = CRC_INIT;
        rv = 8'h3c;
        for (int i = 7; i >= 0; i--) begin
            crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ rv[i]) ? CRC_POLY : 8'h00);
        end
        wrReg(ADDR_DATA, rv);
        wrReg(ADDR_CTRL, 8'h03);
        pulse(0);
        fork
            getBits(17, bits);
            begin
                waitFor(1);
                wrReg(ADDR_CTRL, 8'h0b);
                rdReg(ADDR_STAT, rv);
                check(17'(rv[ST_EMPTY]), 17'h0, "empty cleared");
            end
        join
        check(bits, {1'b1, 8'h3c, ~crc}, "crc frame");
        waitFor(2);
        repeat (BIT_CYCLES * EOD_BITS) @(posedge clock);
        rdReg(ADDR_CTRL, rv);
        check(17'(rv[3:0]), 17'h0, "crc clear");
        pulse(1);
        $display("test crc done");
        // Sets after end of data are ignored
        pulse(0);
        for (int k = 1; k < 3; k++) begin
            wrReg(ADDR_CTRL, 8'h02 << (k - 1));
            rdReg(ADDR_CTRL, rv);
            check(17'(rv), 17'h0, "late set");
        end
        repeat (2000) @(posedge clock);
        check(17'(txEn), 17'h0, "no attempt");
        pulse(1);
        $display("test late set done");
        // Lost arbitration in check mode
        wrReg(ADDR_DATA, 8'hf0);
        wrReg(ADDR_CTRL, 8'h02);
        pulse(0);
        waitFor(0);
        repeat (2400) @(posedge clock);
        jam <= 1'b1;
        waitFor(2);
        jam <= 1'b0;
        rdReg(ADDR_CTRL, rv);
        check(17'(rv), 17'h0, "loss clear");
        rdReg(ADDR_STAT, rv);
        check(17'(rv[ST_LOST]), 17'h1, "lost flag");
        rdReg(ADDR_STAT, rv);
        check(17'(rv[ST_LOST]), 17'h0, "lost read clear");
        pulse(1);
        $display("test loss done");
        completeRun();
    end
endmodule

// file: rtl/ifr_bit_shifter.sv
// Transmit shift register, most significant bit first
`timescale 1ns/1ps
module ifr_bit_shifter (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // Control
    input  wire logic       load,
    input  wire logic       step,
    input  wire logic [7:0] loadByte,
    // State
    output logic            bitOut,
    output logic [3:0]      count
);
    import ifr_pkg::*;

    logic [7:0] sh_ff;
    logic [3:0] cnt_ff;

    // Load with an optional first step in the same cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            sh_ff  <= 8'h00;
            cnt_ff <= BYTE_BITS;
        end else if (load) begin
            sh_ff  <= step ? {loadByte[6:0], 1'b0} : loadByte;
            cnt_ff <= step ? 4'h1 : 4'h0;
        end else if (step && cnt_ff != BYTE_BITS) begin
            sh_ff  <= {sh_ff[6:0], 1'b0};
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    assign bitOut = sh_ff[7];
    assign count  = cnt_ff;
endmodule

// file: rtl/ifr_bit_tick.sv
// Bit-period enable divider for the link
`timescale 1ns/1ps
module ifr_bit_tick (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Control
    input  wire logic restart,
    // Enable pulse
    output logic      tick
);
    import ifr_pkg::*;

    localparam logic [15:0] LAST = 16'(BIT_CYCLES - 1);

    logic [15:0] cnt_ff;
    logic        tick_ff;

    // Free running count, realigned on a received end of data symbol
    always_ff @(posedge clock) begin
        if (reset || restart) begin
            cnt_ff  <= 16'h0000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= (cnt_ff == LAST) ? 16'h0000 : cnt_ff + 16'h0001;
            tick_ff <= (cnt_ff == LAST);
        end
    end

    assign tick = tick_ff;
endmodule

// file: rtl/ifr_pkg.sv
// Shared constants, types and helpers of the in-frame response transmitter
package ifr_pkg;

    // ------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------
    localparam logic [1:0] ADDR_CTRL  = 2'h0;  // Requests, end of data, format
    localparam logic [1:0] ADDR_STAT  = 2'h1;  // State vector
    localparam logic [1:0] ADDR_DATA  = 2'h2;  // Link data register
    localparam int         CTL_NOCRC  = 0;
    localparam int         CTL_CRC    = 1;
    localparam int         CTL_SINGLE = 2;
    localparam int         CTL_EOD    = 3;
    localparam int         CTL_NORM_FORMAT_SEL   = 4;
    localparam int         ST_EMPTY   = 0;
    localparam int         ST_LOST    = 1;
    localparam int         ST_ACTIVE  = 2;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] DATA_RST   = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         CLK_MHZ     = 25;
    localparam int         BIT_TIME_US = 64;
    localparam int         BIT_CYCLES  = BIT_TIME_US * CLK_MHZ;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [3:0] EOD_BITS    = 4'h4;
    localparam logic [3:0] EXTRA_BITS  = 4'h2;
    localparam logic [3:0] LAST_TWO    = 4'h6;

    // ------------------------------------------------------------
    // Check byte
    // ------------------------------------------------------------
    localparam logic [7:0] CRC_POLY = 8'h1d;
    localparam logic [7:0] CRC_INIT = 8'hff;

    // Transmit sequencer states, Gray coded along the usual path
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_NORM  = 3'b001,
        S_BYTE  = 3'b011,
        S_CRC   = 3'b010,
        S_EOD   = 3'b110,
        S_EXTRA = 3'b111,
        S_WAIT  = 3'b101
    } ifrState_e;

    // Register port request
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ifrRegReq_s;

    // Symbol events from the receiver
    typedef struct packed {
        logic eodRx;
        logic eofRx;
        logic busError;
    } ifrRxEvt_s;

    // One step of the check byte over a transmitted bit
    function automatic logic [7:0] crc8Step(input logic [7:0] crc,
                                            input logic       b);
        logic fb;
        fb = crc[7] ^ b;
        return {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    endfunction

endpackage

// file: rtl/ifr_tx_ctrl.sv
// In-frame response transmit control: requests, sequencing, arbitration
//
// Behaviour
// RULE1: Several requests set: single beats with-CRC beats without-CRC.
// RULE2: Request bits read back exactly as software wrote them.
// RULE3: Software sets at most one request bit at a time.
// RULE4: An active normalization bit precedes the first response byte.
// RULE5: One shared normalization bit; its slot is not arbitrated.
// RULE6: Losing node keeps sending its identifier until its byte appears.
// RULE7: Single request before end of data sends normalization then byte.
// RULE8: Single request clears on success, end-of-data request, bus error.
// RULE9: Single request cannot be set just after end of data.
// RULE10: Single byte lost: wait winner, resend without normalization bit.
// RULE11: Single byte lost in last two bits sends no extra ones.
// RULE12: With-CRC: normalization, bytes, then check byte and end of data.
// RULE13: Multi-byte modes flag transmit empty after each byte load.
// RULE14: With-CRC request clears on completion, bus error or underrun.
// RULE15: Single byte plus check byte raises no further transmit empty.
// RULE16: With-CRC request cannot be set just after end of data.
// RULE17: With-CRC loss sets flag, stops, clears request, no resend.
// RULE18: With-CRC loss in last two bits sends two extra ones; code sends them for a loss in any of the last three bits.
// RULE19: Without-CRC: normalization, bytes, last written byte ends it.
// RULE20: Software sets end-of-data request after the last byte write.
// RULE21: Without-CRC request clears on completion, bus error, underrun.
// RULE22: Format select picks normalization bit polarity per CRC use.
// RULE23: Setting end-of-data request clears transmit empty.
// RULE24: All request bits reset to zero.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
module ifr_tx_ctrl (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // Register port
    input  ifr_pkg::ifrRegReq_s regReq,
    output logic [7:0]       rdData,
    // Receiver symbol events
    input  ifr_pkg::ifrRxEvt_s  rxEvt,
    // Link pins
    input  wire logic        busRxPin,
    output logic             txBit,
    output logic             txEn,
    // Status
    output logic             txEmpty,
    output logic             lostArb
);
    import ifr_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic       rxMeta_ff;
    logic       rxSync_ff;
    logic [2:0] reqRaw_ff;
    logic       eodReq_ff;
    logic       norm_format_sel_ff;
    logic [7:0] dataReg_ff;
    logic       dataFull_ff;
    logic       txEmpty_ff;
    logic       lostArb_ff;
    logic       svRead_ff;
    logic       eodSeen_ff;
    logic [7:0] crc_ff;
    logic [7:0] holdByte_ff;
    logic [3:0] waitCnt_ff;
    logic       armArb_ff;
    logic       txBit_ff;
    logic       txEn_ff;
    logic [7:0] rdData_ff;
    ifrState_e  state_ff;

    // ------------------------------------------------------------
    // Next values and controls
    // ------------------------------------------------------------
    ifrState_e  nxt_state;
    logic [3:0] nxt_waitCnt;
    logic       nxt_txBit;
    logic       nxt_txEn;
    logic       nxt_armArb;
    logic       shLoad;
    logic       shStep;
    logic [7:0] shByte;
    logic       clrReq;
    logic       clrEod;
    logic       setEmpty;
    logic       setLost;
    logic       takeData;
    logic       crcInit;
    logic       bitTick;
    logic       shBit;
    logic [3:0] shCnt;

    // Divider and shift register
    ifr_bit_tick u_tick (
        .clock   (clock),
        .reset   (reset),
        .restart (rxEvt.eodRx),
        .tick    (bitTick)
    );
    ifr_bit_shifter u_shift (
        .clock    (clock),
        .reset    (reset),
        .load     (shLoad),
        .step     (shStep),
        .loadByte (shByte),
        .bitOut   (shBit),
        .count    (shCnt)
    );
    // Register decode
    wire wrCtrl = regReq.wr && regReq.addr == ADDR_CTRL;
    wire wrData = regReq.wr && regReq.addr == ADDR_DATA;
    wire rdStat = regReq.rd && regReq.addr == ADDR_STAT;
    // Priority encoding of the request bits
    wire actSingle = reqRaw_ff[CTL_SINGLE];                          // RULE1
    wire actCrc    = ~reqRaw_ff[CTL_SINGLE] & reqRaw_ff[CTL_CRC];    // RULE1
    wire actNocrc  = ~reqRaw_ff[CTL_SINGLE] & ~reqRaw_ff[CTL_CRC]
                     & reqRaw_ff[CTL_NOCRC];                         // RULE1
    wire actMulti  = actCrc | actNocrc;
    wire anyReq    = actSingle | actMulti;
    wire busy      = state_ff != S_IDLE;
    // Normalization bit polarity
    wire nbVal = norm_format_sel_ff ^ actCrc;                                   // RULE22
    // Sets are refused between end of data and end of frame while the sequencer is idle
    wire        setBlock = eodSeen_ff && !busy;                      // RULE9 RULE16
    wire [2:0]  reqWrite = setBlock ? (regReq.wdata[2:0] & reqRaw_ff)
                                    : regReq.wdata[2:0];
    wire        eodWrite = wrCtrl && regReq.wdata[CTL_EOD];
    // Arbitration check of the last bit shown
    wire lostNow  = bitTick && txEn_ff && armArb_ff
                    && (rxSync_ff != txBit_ff);
    wire lastTwo  = shCnt >= LAST_TWO;
    wire byteDone = shCnt == BYTE_BITS;
    // Read mux
    wire [7:0] ctrlView = {3'h0, norm_format_sel_ff, eodReq_ff, reqRaw_ff};    // RULE2
    wire [7:0] statView = {5'h00, busy, lostArb_ff, txEmpty_ff};
    wire [7:0] rdValue  = (regReq.addr == ADDR_CTRL) ? ctrlView :
                          (regReq.addr == ADDR_STAT) ? statView :
                          (regReq.addr == ADDR_DATA) ? dataReg_ff : 8'h00;
    // Sequencer next state and side effects
    always_comb begin
        nxt_state   = state_ff;
        nxt_waitCnt = waitCnt_ff;
        nxt_txBit   = txBit_ff;
        nxt_txEn    = txEn_ff;
        nxt_armArb  = armArb_ff;
        shLoad      = 1'b0;
        shStep      = 1'b0;
        shByte      = dataReg_ff;
        clrReq      = 1'b0;
        clrEod      = 1'b0;
        setEmpty    = 1'b0;
        setLost     = 1'b0;
        takeData    = 1'b0;
        crcInit     = 1'b0;
        case (state_ff)
            S_IDLE: begin
                nxt_txEn   = 1'b0;
                nxt_armArb = 1'b0;
                if (rxEvt.eodRx && anyReq && !rxEvt.busError) begin
                    nxt_state = S_NORM;                 // RULE7 RULE12 RULE19
                end
            end
            S_NORM: begin
                if (bitTick) begin
                    nxt_txBit  = nbVal;                 // RULE4
                    nxt_txEn   = 1'b1;
                    nxt_armArb = 1'b0;                  // RULE5
                    shLoad     = 1'b1;
                    takeData   = 1'b1;
                    crcInit    = 1'b1;
                    setEmpty   = actMulti;              // RULE13
                    nxt_state  = S_BYTE;
                end
            end
            S_BYTE, S_CRC: begin
                if (lostNow && actSingle) begin
                    nxt_txEn    = 1'b0;                 // RULE11
                    nxt_armArb  = 1'b0;
                    nxt_waitCnt = BYTE_BITS - shCnt;
                    nxt_state   = S_WAIT;               // RULE10
                end else if (lostNow) begin
                    setLost     = 1'b1;                 // RULE17
                    clrReq      = 1'b1;                 // RULE17
                    nxt_armArb  = 1'b0;
                    nxt_waitCnt = EXTRA_BITS;
                    nxt_txBit   = 1'b1;
                    nxt_txEn    = lastTwo;              // RULE18
                    nxt_state   = lastTwo ? S_EXTRA : S_IDLE;
                end else if (bitTick && !byteDone) begin
                    nxt_txBit  = shBit;
                    nxt_armArb = 1'b1;
                    shStep     = 1'b1;
                end else if (bitTick && state_ff == S_CRC) begin
                    nxt_txEn    = 1'b0;
                    nxt_armArb  = 1'b0;
                    nxt_waitCnt = EOD_BITS;
                    nxt_state   = S_EOD;                // RULE12
                end else if (bitTick && actSingle) begin
                    clrReq    = 1'b1;                   // RULE8
                    nxt_txEn  = 1'b0;
                    nxt_state = S_IDLE;
                end else if (bitTick && dataFull_ff) begin
                    shLoad    = 1'b1;
                    shStep    = 1'b1;
                    takeData  = 1'b1;
                    nxt_txBit = dataReg_ff[7];
                    setEmpty  = !eodReq_ff;             // RULE13 RULE15
                end else if (bitTick && eodReq_ff && actCrc) begin
                    shLoad    = 1'b1;
                    shStep    = 1'b1;
                    shByte    = ~crc_ff;
                    nxt_txBit = ~crc_ff[7];
                    nxt_state = S_CRC;                  // RULE12
                end else if (bitTick && eodReq_ff) begin
                    nxt_txEn    = 1'b0;                 // RULE19
                    nxt_armArb  = 1'b0;
                    nxt_waitCnt = EOD_BITS;
                    nxt_state   = S_EOD;
                end else if (bitTick) begin
                    clrReq    = 1'b1;                   // RULE14 RULE21
                    nxt_txEn  = 1'b0;
                    nxt_state = S_IDLE;
                end
            end
            S_WAIT: begin
                if (!actSingle) begin
                    nxt_state = S_IDLE;
                end else if (bitTick && waitCnt_ff <= 4'h1) begin
                    shLoad     = 1'b1;                  // RULE6 RULE10
                    shStep     = 1'b1;
                    shByte     = holdByte_ff;
                    nxt_txBit  = holdByte_ff[7];
                    nxt_txEn   = 1'b1;
                    nxt_armArb = 1'b1;
                    nxt_state  = S_BYTE;
                end else if (bitTick) begin
                    nxt_waitCnt = waitCnt_ff - 4'h1;
                end
            end
            S_EXTRA: begin
                if (bitTick && waitCnt_ff <= 4'h1) begin
                    nxt_txEn  = 1'b0;
                    nxt_state = S_IDLE;
                end else if (bitTick) begin
                    nxt_waitCnt = waitCnt_ff - 4'h1;    // RULE18
                end
            end
            S_EOD: begin
                if (bitTick && waitCnt_ff <= 4'h1) begin
                    clrReq    = 1'b1;                   // RULE14 RULE21
                    clrEod    = 1'b1;
                    nxt_state = S_IDLE;
                end else if (bitTick) begin
                    nxt_waitCnt = waitCnt_ff - 4'h1;
                end
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
        // Bus error, or end-of-data request in single mode, ends the response at once
        if (rxEvt.busError || (actSingle && eodReq_ff)) begin
            clrReq    = 1'b1;                           // RULE8 RULE14 RULE21
            clrEod    = rxEvt.busError;
            setEmpty  = 1'b0;
            nxt_txEn  = 1'b0;
            nxt_state = S_IDLE;
        end
    end

    // Pin synchroniser
    always_ff @(posedge clock) begin
        rxMeta_ff <= busRxPin;
        rxSync_ff <= rxMeta_ff;
    end
    // Control register; software writes win over hardware clears
    always_ff @(posedge clock) begin
        if (reset) begin
            reqRaw_ff <= CTRL_RST[2:0];                 // RULE24
            eodReq_ff <= CTRL_RST[CTL_EOD];
            norm_format_sel_ff   <= CTRL_RST[CTL_NORM_FORMAT_SEL];
        end else begin
            if (wrCtrl) begin
                reqRaw_ff <= reqWrite;                  // RULE2
                norm_format_sel_ff   <= regReq.wdata[CTL_NORM_FORMAT_SEL];
            end else if (clrReq) begin
                reqRaw_ff <= 3'h0;                      // RULE8
            end
            if (eodWrite) begin
                eodReq_ff <= 1'b1;
            end else if (clrEod || (wrCtrl && !busy)) begin
                eodReq_ff <= 1'b0;
            end
        end
    end
    // Data register and the transmit-empty handshake
    always_ff @(posedge clock) begin
        if (reset) begin
            dataReg_ff  <= DATA_RST;
            dataFull_ff <= 1'b0;
            txEmpty_ff  <= 1'b0;
            svRead_ff   <= 1'b0;
        end else begin
            if (wrData) begin
                dataReg_ff <= regReq.wdata;
            end
            dataFull_ff <= wrData || (dataFull_ff && !takeData);
            svRead_ff   <= rdStat || (svRead_ff && !wrData);
            if (setEmpty) begin
                txEmpty_ff <= 1'b1;
            end else if (eodWrite || (wrData && svRead_ff)) begin
                txEmpty_ff <= 1'b0;                     // RULE23
            end
        end
    end
    // Status flags and frame tracking
    always_ff @(posedge clock) begin
        if (reset) begin
            lostArb_ff <= 1'b0;
            eodSeen_ff <= 1'b0;
        end else begin
            lostArb_ff <= setLost || (lostArb_ff && !rdStat);
            eodSeen_ff <= rxEvt.eodRx || (eodSeen_ff && !rxEvt.eofRx);
        end
    end
    // Check byte over data bits sent, byte held for retries
    always_ff @(posedge clock) begin
        if (reset) begin
            crc_ff      <= CRC_INIT;
            holdByte_ff <= DATA_RST;
        end else begin
            if (crcInit) begin
                crc_ff <= CRC_INIT;
            end else if (shStep && state_ff == S_BYTE) begin
                crc_ff <= crc8Step(crc_ff, nxt_txBit);
            end
            if (takeData) begin
                holdByte_ff <= dataReg_ff;
            end
        end
    end

    // Sequencer and pin registers
    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff   <= S_IDLE;
            waitCnt_ff <= 4'h0;
            txBit_ff   <= 1'b0;
            txEn_ff    <= 1'b0;
            armArb_ff  <= 1'b0;
            rdData_ff  <= 8'h00;
        end else begin
            state_ff   <= nxt_state;
            waitCnt_ff <= nxt_waitCnt;
            txBit_ff   <= nxt_txBit;
            txEn_ff    <= nxt_txEn;
            armArb_ff  <= nxt_armArb;
            rdData_ff  <= regReq.rd ? rdValue : 8'h00;
        end
    end

    assign rdData  = rdData_ff;
    assign txBit   = txBit_ff;
    assign txEn    = txEn_ff;
    assign txEmpty = txEmpty_ff;
    assign lostArb = lostArb_ff;
endmodule
